// *** logic/pic_top.sv ***
// Prioritized interrupt controller with APB register access
// Functional notes
// - Five pins, NMI, timers, DMA, serial accepted
// - Pending requests ranked, offered one at a time
// - Each pin works as direct request in master mode
// - Slave mode serves external cascaded master
// - Higher priority nests over lower
// - Acceptance blocks; set IF allows equal/higher
// - In-service bit blocks same source
// - Special nesting ignores in-service for pins 0/1
// - Power-on priority levels unless reprogrammed
// - NMI type 02h, vector 08h, no END_OF_SERVICE_CODE
// - Exceptions type 00h-07h except 02h, highest, no END_OF_SERVICE_CODE
// - Timers share one request, ranked 0>1>2
// - DMA0 type 0Ah, priority 3
// - DMA1 type 0Bh, priority 4
// - Pin 0 type 0Ch, priority 5
// - Pins 1-3 types 0Dh-0Fh, priorities 6-8
// - Pin 4, watchdog, serial lowest; off in slave
// - Slave mode: timer/DMA types programmable
// - Types 09h, 15h-1Fh never generated in master mode
`timescale 1ns/1ps
module pic_top import pic_pkg::*; (
  input  wire logic        pclk,               // APB clock, 20 MHz
  input  wire logic        presetn,            // Async reset, active low
  input  wire logic [7:0]  paddr,              // APB byte address
  input  wire logic        psel,               // APB select
  input  wire logic        penable,            // APB enable
  input  wire logic        pwrite,             // APB write
  input  wire logic [31:0] pwdata,             // APB write data
  output logic      [31:0] prdata,             // APB read data
  output logic             pready,             // APB ready
  output logic             pslverr,            // APB error
  input  wire logic [4:0]  external_request_pins, // Maskable request pins
  input  wire logic        nmi_pin,            // Non-maskable pin, rising edge
  input  wire logic [7:0]  cascade_type,       // Type from external master
  input  wire logic [2:0]  tmr_evt,            // Timer 2..0 event pulses
  input  wire logic [1:0]  dma_evt,            // DMA 1..0 done pulses
  input  wire logic        wdog_evt,           // Watchdog event pulse
  input  wire logic        ser_evt,            // Serial port event pulse
  input  wire logic        exc_req,            // Instruction exception pulse
  input  wire logic [2:0]  exc_code,           // Exception type code
  input  wire logic        cpu_if,             // Processor interrupt-enable flag
  input  wire logic        cpu_ack,            // Processor accepts offer
  output pic_req_t         cpu_req             // Offered request to processor
);

  // ==========================================================================
  // Pin synchronisers
  logic [4:0] pin_s;
  logic       nmi_s;
  logic [7:0] cas_s;

  pic_sync #(.WIDTH(14)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   ({cascade_type, nmi_pin, external_request_pins}),
    .dout  ({cas_s, nmi_s, pin_s})
  );

  // ==========================================================================
  // State
  logic [7:0]  ctrl_q;
  logic [9:0]  mask_q;
  logic [29:0] prio_q;
  logic [4:0]  sbase_q;
  logic [9:0]  insv_q;
  logic [2:0]  tmr_pend_q;
  logic [1:0]  dma_pend_q;
  logic [4:0]  pin_edge_q, pin_prev_q;
  logic        wdog_pend_q, ser_pend_q, nmi_prev_q, nmi_pend_q;
  logic        exc_pend_q, if_prev_q, if_ok_q;
  logic [2:0]  exc_code_q;
  pic_state_t  st_q;
  pic_kind_t   cur_kind_q;
  logic [3:0]  cur_src_q;
  logic [1:0]  cur_sub_q;
  logic [7:0]  cur_code_q;

  logic        slave, commit, take_msk, bus_go, wr_go, eoi_wr;
  logic [9:0]  pend, elig, eoi_clr, insv_set;
  logic [1:0]  tsub;
  logic [7:0]  m_code;
  pic_pick_t   mpick, ipick;

  assign slave    = ctrl_q[CTRL_SLAVE];
  assign commit   = (st_q == ST_OFFER) && cpu_ack;
  assign take_msk = commit && (cur_kind_q == K_MSK);
  assign bus_go   = psel && penable && !pready;
  assign wr_go    = psel && penable && pready && pwrite;
  assign eoi_wr   = wr_go && (paddr == OFS_EOI);

  // ==========================================================================
  // Request collection
  always_comb begin
    pend               = '0;
    pend[SRC_TMR-1]    = |tmr_pend_q;
    pend[SRC_DMA0-1]   = dma_pend_q[0];
    pend[SRC_DMA1-1]   = dma_pend_q[1];
    pend[SRC_WDOG-1]   = wdog_pend_q;
    pend[SRC_SER-1]    = ser_pend_q;
    for (int k = 0; k < 5; k++) begin
      // Level mode follows the pin, edge mode holds a latched edge
      pend[SRC_INT0-1+k] = ctrl_q[CTRL_TRIG_LSB+k] ? pin_s[k] : pin_edge_q[k];
    end
  end

  // Highest level currently in service
  pic_pick #(.N(NMSK)) u_isr_pick (
    .req  (insv_q),
    .lvls (prio_q),
    .pick (ipick)
  );

  always_comb begin
    logic [2:0] l;
    logic       blk, off;
    l    = '0;
    blk  = 1'b0;
    off  = 1'b0;
    elig = '0;
    for (int i = 0; i < NMSK; i++) begin
      l   = prio_q[3*i +: 3];
      blk = insv_q[i] && !((i == SRC_INT0-1 && ctrl_q[CTRL_SFN0]) ||
                           (i == SRC_INT1-1 && ctrl_q[CTRL_SFN1]));
      // Slave mode: pins 1..4, watchdog and serial drop out
      off = slave && (i >= SRC_INT1-1);
      elig[i] = pend[i] && !mask_q[i] && !blk && !off &&
                (!ipick.hit || l <= ipick.lvl);
    end
  end

  pic_pick #(.N(NMSK)) u_req_pick (
    .req  (elig),
    .lvls (prio_q),
    .pick (mpick)
  );

  // Timers among themselves: 0 over 1 over 2
  assign tsub = tmr_pend_q[0] ? 2'h0 : (tmr_pend_q[1] ? 2'h1 : 2'h2);

  // Type code of the winning maskable source
  always_comb begin
    m_code = '0;
    case (4'(mpick.idx + 4'h1))
      4'(SRC_TMR): begin
        case (tsub)
          2'h0:    m_code = slave ? {sbase_q, SLV_TMR0} : TYPE_TMR0;
          2'h1:    m_code = slave ? {sbase_q, SLV_TMR1} : TYPE_TMR1;
          default: m_code = slave ? {sbase_q, SLV_TMR2} : TYPE_TMR2;
        endcase
      end
      4'(SRC_DMA0): m_code = slave ? {sbase_q, SLV_DMA0} : TYPE_DMA0;
      4'(SRC_DMA1): m_code = slave ? {sbase_q, SLV_DMA1} : TYPE_DMA1;
      4'(SRC_INT0): m_code = slave ? cas_s : TYPE_INT0;
      4'(SRC_WDOG): m_code = TYPE_WDOG;
      4'(SRC_SER):  m_code = TYPE_SER;
      default:      m_code = 8'(TYPE_INT0 + 8'(mpick.idx) - 8'(SRC_INT0 - 1));
    endcase
  end

  // ==========================================================================
  // End-of-service decode
  always_comb begin
    logic [7:0] c;
    c       = '0;
    eoi_clr = '0;
    if (eoi_wr) begin
      if (pwdata[EOI_NSPEC]) begin
        eoi_clr[ipick.idx] = ipick.hit;
      end else begin
        for (int i = 0; i < NMSK; i++) begin
          case (i + 1)
            SRC_TMR:  c = slave ? {sbase_q, SLV_TMR0} : TYPE_TMR0;
            SRC_DMA0: c = slave ? {sbase_q, SLV_DMA0} : TYPE_DMA0;
            SRC_DMA1: c = slave ? {sbase_q, SLV_DMA1} : TYPE_DMA1;
            SRC_WDOG: c = TYPE_WDOG;
            SRC_SER:  c = TYPE_SER;
            default:  c = 8'(TYPE_INT0 + 8'(i) - 8'(SRC_INT0 - 1));
          endcase
          eoi_clr[i] = (pwdata[7:0] == c);
        end
      end
    end
  end

  assign insv_set = take_msk ? (10'h001 << (cur_src_q - 4'h1)) : 10'h000;

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insv_q <= '0;
    end else begin
      insv_q <= (insv_q & ~eoi_clr) | insv_set;
    end
  end

  // ==========================================================================
  // Pending latches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_pend_q  <= '0;
      dma_pend_q  <= '0;
      wdog_pend_q <= 1'b0;
      ser_pend_q  <= 1'b0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        tmr_pend_q[k] <= tmr_evt[k] | (tmr_pend_q[k] & !(take_msk &&
                         cur_src_q == 4'(SRC_TMR) && cur_sub_q == 2'(k)));
      end
      dma_pend_q[0] <= dma_evt[0] | (dma_pend_q[0] & !(take_msk && cur_src_q == 4'(SRC_DMA0)));
      dma_pend_q[1] <= dma_evt[1] | (dma_pend_q[1] & !(take_msk && cur_src_q == 4'(SRC_DMA1)));
      wdog_pend_q   <= wdog_evt | (wdog_pend_q & !(take_msk && cur_src_q == 4'(SRC_WDOG)));
      ser_pend_q    <= ser_evt | (ser_pend_q & !(take_msk && cur_src_q == 4'(SRC_SER)));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_q <= '0;
      pin_edge_q <= '0;
    end else begin
      pin_prev_q <= pin_s;
      for (int k = 0; k < 5; k++) begin
        pin_edge_q[k] <= (pin_s[k] & !pin_prev_q[k]) | (pin_edge_q[k] & !(commit &&
                         cur_kind_q == K_MSK && cur_src_q == 4'(SRC_INT0 + k)));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_s;
      nmi_pend_q <= (nmi_s & !nmi_prev_q) |
                    (nmi_pend_q & !(commit && cur_kind_q == K_NMI));
    end
  end

  // Slot 2 belongs to the non-maskable input, never an exception
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exc_pend_q <= 1'b0;
      exc_code_q <= '0;
    end else if (exc_req && exc_code != EXC_NMI_SLOT) begin
      exc_pend_q <= 1'b1;
      exc_code_q <= exc_code;
    end else if (commit && cur_kind_q == K_EXC) begin
      exc_pend_q <= 1'b0;
    end
  end

  // Acceptance holds off maskable offers until the flag rises again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      if_prev_q <= 1'b0;
      if_ok_q   <= 1'b1;
    end else begin
      if_prev_q <= cpu_if;
      if (cpu_if && !if_prev_q) begin
        if_ok_q <= 1'b1;
      end else if (commit) begin
        if_ok_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Offer to the processor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= ST_IDLE;
      cur_kind_q <= K_EXC;
      cur_src_q  <= '0;
      cur_sub_q  <= '0;
      cur_code_q <= '0;
      cpu_req    <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (exc_pend_q) begin
            cur_kind_q <= K_EXC;
            cur_code_q <= {5'h00, exc_code_q};
            cpu_req    <= '{valid: 1'b1, code: {5'h00, exc_code_q},
                            vector: pic_vec({5'h00, exc_code_q})};
            st_q       <= ST_OFFER;
          end else if (nmi_pend_q) begin
            cur_kind_q <= K_NMI;
            cur_code_q <= TYPE_NMI;
            cpu_req    <= '{valid: 1'b1, code: TYPE_NMI, vector: pic_vec(TYPE_NMI)};
            st_q       <= ST_OFFER;
          end else if (mpick.hit && cpu_if && if_ok_q) begin
            cur_kind_q <= K_MSK;
            cur_src_q  <= 4'(mpick.idx + 4'h1);
            cur_sub_q  <= tsub;
            cur_code_q <= m_code;
            cpu_req    <= '{valid: 1'b1, code: m_code, vector: pic_vec(m_code)};
            st_q       <= ST_OFFER;
          end
        end
        ST_OFFER: begin
          if (cpu_ack) begin
            cpu_req <= '0;
            st_q    <= ST_ACK;
          end
        end
        ST_ACK:   st_q <= ST_IDLE;
        default: begin
          st_q    <= ST_IDLE;
          cpu_req <= '0;
        end
      endcase
    end
  end

  // ==========================================================================
  // APB slave: answers one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= CTRL_RST;
      mask_q  <= MASK_RST;
      prio_q  <= PRIO_RST;
      sbase_q <= SBASE_RST;
    end else if (wr_go) begin
      case (paddr)
        OFS_CTRL:  ctrl_q  <= pwdata[7:0];
        OFS_MASK:  mask_q  <= pwdata[9:0];
        OFS_PRIO:  prio_q  <= pwdata[29:0];
        // Base never below 01h keeps slave types clear of 00h-07h
        OFS_SBASE: sbase_q <= (pwdata[7:3] == 5'h00) ? SBASE_RST : pwdata[7:3];
        default:   ctrl_q  <= ctrl_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= bus_go;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (bus_go) begin
        case (paddr)
          OFS_CTRL:  prdata <= {24'h0, ctrl_q};
          OFS_MASK:  prdata <= {22'h0, mask_q};
          OFS_PRIO:  prdata <= {2'h0, prio_q};
          OFS_EOI:   prdata <= '0;
          OFS_INSV:  prdata <= {22'h0, insv_q};
          OFS_PEND:  prdata <= {9'h0, exc_pend_q, nmi_pend_q, tmr_pend_q, 8'h0, pend};
          OFS_SBASE: prdata <= {24'h0, sbase_q, 3'h0};
          OFS_STAT:  prdata <= {19'h0, cur_kind_q, st_q, cur_code_q};
          default:   pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// *** include/pic_pkg.sv ***
// Shared constants, types and helpers for the prioritized interrupt controller
package pic_pkg;

  // ==========================================================================
  // Source numbering (maskable sources 1..10, 0 is the non-maskable input)
  // ==========================================================================
  localparam int NSRC     = 11;
  localparam int NMSK     = 10;
  localparam int SRC_TMR  = 1;
  localparam int SRC_DMA0 = 2;
  localparam int SRC_DMA1 = 3;
  localparam int SRC_INT0 = 4;
  localparam int SRC_INT1 = 5;
  localparam int SRC_INT4 = 8;
  localparam int SRC_WDOG = 9;
  localparam int SRC_SER  = 10;

  // ==========================================================================
  // Fixed type codes
  // ==========================================================================
  localparam logic [7:0] TYPE_NMI  = 8'h02;
  localparam logic [7:0] TYPE_TMR0 = 8'h08;
  localparam logic [7:0] TYPE_TMR1 = 8'h12;
  localparam logic [7:0] TYPE_TMR2 = 8'h13;
  localparam logic [7:0] TYPE_DMA0 = 8'h0A;
  localparam logic [7:0] TYPE_DMA1 = 8'h0B;
  localparam logic [7:0] TYPE_INT0 = 8'h0C;
  localparam logic [7:0] TYPE_WDOG = 8'h11;
  localparam logic [7:0] TYPE_SER  = 8'h14;
  localparam logic [2:0] EXC_NMI_SLOT = 3'h2;

  // Slave mode: low three type bits added to the programmed base
  localparam logic [2:0] SLV_TMR0 = 3'h0;
  localparam logic [2:0] SLV_DMA0 = 3'h2;
  localparam logic [2:0] SLV_DMA1 = 3'h3;
  localparam logic [2:0] SLV_TMR1 = 3'h4;
  localparam logic [2:0] SLV_TMR2 = 3'h5;

  // ==========================================================================
  // Register map (byte addresses) and fields
  // ==========================================================================
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_MASK  = 8'h04;
  localparam logic [7:0] OFS_PRIO  = 8'h08;
  localparam logic [7:0] OFS_EOI   = 8'h0C;
  localparam logic [7:0] OFS_INSV  = 8'h10;
  localparam logic [7:0] OFS_PEND  = 8'h14;
  localparam logic [7:0] OFS_SBASE = 8'h18;
  localparam logic [7:0] OFS_STAT  = 8'h1C;

  localparam int CTRL_SLAVE    = 0;
  localparam int CTRL_SFN0     = 1;
  localparam int CTRL_SFN1     = 2;
  localparam int CTRL_TRIG_LSB = 3;
  localparam int EOI_NSPEC     = 15;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [9:0]  MASK_RST  = 10'h3FF;
  localparam logic [4:0]  SBASE_RST = 5'h01;
  // Power-on levels, source 10 down to 1; lower value ranks higher
  localparam logic [29:0] PRIO_RST  = {3'h7, 3'h7, 3'h7, 3'h6, 3'h5,
                                       3'h4, 3'h3, 3'h2, 3'h1, 3'h0};

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [9:0] vector;
  } pic_req_t;

  typedef struct packed {
    logic       hit;
    logic [3:0] idx;
    logic [2:0] lvl;
  } pic_pick_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_OFFER = 3'b010,
    ST_ACK   = 3'b100
  } pic_state_t;

  typedef enum logic [1:0] {
    K_EXC = 2'h0,
    K_NMI = 2'h1,
    K_MSK = 2'h2
  } pic_kind_t;

  function automatic logic [9:0] pic_vec(input logic [7:0] code);
    return {code, 2'h0};
  endfunction

endpackage

// *** logic/pic_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // Clock
  input  wire logic             rst_n, // Async reset, active low
  input  wire logic [WIDTH-1:0] din,   // Asynchronous input
  output logic      [WIDTH-1:0] dout   // Synchronised output
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// *** logic/pic_pick.sv ***
// Picks the best request by level; ties go to the lower position
`timescale 1ns/1ps
module pic_pick import pic_pkg::*; #(
  parameter int N = 10
) (
  input  wire logic [N-1:0]   req,  // Candidate requests
  input  wire logic [3*N-1:0] lvls, // Three-bit level per position
  output pic_pick_t           pick  // Winner
);

  always_comb begin
    pick = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!pick.hit || lvls[3*i +: 3] < pick.lvl)) begin
        pick.hit = 1'b1;
        pick.idx = 4'(i);
        pick.lvl = lvls[3*i +: 3];
      end
    end
  end

endmodule

// *** tb/pic_top_monitor.sv ***
// Port checker for the interrupt controller
`timescale 1ns/1ps
module pic_top_monitor import pic_pkg::*; (
  input wire logic        pclk,    // Clock
  input wire logic        presetn, // Reset, active low
  input wire logic        psel,    // APB select
  input wire logic        penable, // APB enable
  input wire logic        pready,  // APB ready
  input wire logic        pslverr, // APB error
  input wire logic [31:0] prdata,  // APB read data
  input wire logic        cpu_if,  // Interrupt enable flag
  input wire logic        cpu_ack, // Offer accepted
  input wire pic_req_t    cpu_req  // Offered request
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ======================================
  // Offer properties
  a_vec_times_four: assert property (cpu_req.valid |->
    cpu_req.vector == {cpu_req.code, 2'h0}) else $error("vector mismatch");
  a_offer_stands: assert property (cpu_req.valid && !cpu_ack |=>
    cpu_req.valid && $stable(cpu_req)) else $error("offer changed");
  a_ack_gap: assert property (cpu_req.valid && cpu_ack |=>
    !cpu_req.valid [*2]) else $error("offer too soon after ack");
  a_if_blocks: assert property ($rose(cpu_req.valid) && !$past(cpu_if) |->
    cpu_req.code < 8'h08) else $error("maskable offered with flag clear");
  a_no_reserved: assert property (cpu_req.valid |-> cpu_req.code != 8'h09 &&
    !(cpu_req.code >= 8'h15 && cpu_req.code <= 8'h1F)) else $error("reserved type");
  // ======================================
  // Bus properties
  a_ready_next: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
endmodule

bind pic_top pic_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .cpu_if(cpu_if), .cpu_ack(cpu_ack), .cpu_req(cpu_req));

// *** tb/pic_cpu_model.sv ***
// Processor side: accepts offers after a chosen lag
`timescale 1ns/1ps
module pic_cpu_model import pic_pkg::*; (
  input  wire logic       pclk,    // Clock
  input  wire logic       presetn, // Reset, active low
  input  wire pic_req_t   cpu_req, // Offered request
  input  wire logic [3:0] lag,     // Cycles to wait before accepting
  output logic            cpu_ack  // Accept pulse
);
  logic [3:0] wait_q;
  // ======================================
  // Accept only while an offer stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      wait_q  <= 4'h0;
    end else begin
      wait_q  <= (!cpu_req.valid || cpu_ack) ? 4'h0 : wait_q + 4'h1;
      cpu_ack <= cpu_req.valid && !cpu_ack && wait_q >= lag;
    end
  end
endmodule

// *** tb/pic_top_bench.sv ***
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module pic_top_bench import pic_pkg::*; ;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, cas = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic        pready, pslverr, cpu_ack;
  logic [4:0]  external_request_pins = 0;
  logic [2:0]  tmr_evt = 0, exc_code = 0;
  logic [1:0]  dma_evt = 0;
  logic        nmi_pin = 0, wdog_evt = 0, ser_evt = 0, exc_req = 0, cpu_if = 0;
  logic [3:0]  lag = 0;
  pic_req_t    cpu_req;
  int          err_count = 0, comparisons = 0;
  logic [7:0]  q[$];
  logic [7:0]  codes [12] = '{8'h08, 8'h12, 8'h13, 8'h0A, 8'h0B, 8'h0C, 8'h0D,
                              8'h0E, 8'h0F, 8'h10, 8'h11, 8'h14};
  pic_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_request_pins(external_request_pins),
    .nmi_pin(nmi_pin), .cascade_type(cas), .tmr_evt(tmr_evt), .dma_evt(dma_evt),
    .wdog_evt(wdog_evt), .ser_evt(ser_evt), .exc_req(exc_req), .exc_code(exc_code),
    .cpu_if(cpu_if), .cpu_ack(cpu_ack), .cpu_req(cpu_req));
  pic_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .lag(lag),
    .cpu_ack(cpu_ack));
  // ======================================
  // Clock, watchdog and verdict
  initial begin
    forever #25 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end
  task automatic summarize();
    $display("mismatches %0d of %0d checks", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ======================================
  // Bus and service tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    `CHK("pready", 1'b1, pready)
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic fire(input logic [11:0] m);
    {ser_evt, wdog_evt, external_request_pins, dma_evt, tmr_evt} <= m;
    @(posedge pclk);
    {ser_evt, wdog_evt, external_request_pins, dma_evt, tmr_evt} <= 12'h000;
    repeat (4) @(posedge pclk);
  endtask
  task automatic svc(input logic ifv, output logic [7:0] c);
    int n;
    n = 0;
    lag <= 4'($urandom_range(3));
    cpu_if <= 1'b0;
    @(posedge pclk);
    cpu_if <= ifv;
    do @(posedge pclk); while (!(cpu_req.valid === 1'b1 && cpu_ack === 1'b1) && ++n < 100);
    c = cpu_req.code;
    `CHK("offer", 1'b1, cpu_req.valid & cpu_ack)
    `CHK("vector", {c, 2'h0}, cpu_req.vector)
    cpu_if <= 1'b0;
  endtask
  task automatic end_of_service_code(input logic [7:0] c);
    wr(OFS_EOI, {24'h0, (c == 8'h12 || c == 8'h13) ? 8'h08 : c});
  endtask
  // ======================================
  // Main sequence
  initial begin
    logic [7:0]  c, x;
    logic [11:0] m;
    logic [31:0] r;
    logic        e;
    int          n;
    void'($urandom(32'h5CEA));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_PRIO, 32'h0, r, e);
    `CHK("prio", {2'h0, PRIO_RST}, r)
    apb(1'b0, 8'h20, 32'h0, r, e);
    `CHK("slverr", 1'b1, e)
    wr(OFS_MASK, 32'h0);
    for (int i = 0; i < 20; i++) begin
      m = (i < 12) ? 12'(1 << i) : 12'($urandom);
      fire(m);
      for (int s = 0; s < 12; s++) if (m[s]) q.push_back(codes[s]);
      while (q.size() > 0) begin
        x = q.pop_front();
        svc(1'b1, c);
        `CHK("code", x, c)
        end_of_service_code(c);
      end
    end
    nmi_pin <= 1'b1;
    svc(1'b0, c);
    `CHK("nmi", 8'h02, c)
    nmi_pin <= 1'b0;
    for (int k = 0; k < 8; k++) if (k != 2) begin
      exc_code <= 3'(k);
      exc_req <= 1'b1;
      @(posedge pclk);
      exc_req <= 1'b0;
      svc(1'b0, c);
      `CHK("exception", 8'(k), c)
    end
    fire(12'h080);
    svc(1'b1, c);
    fire(12'h088);
    svc(1'b1, c);
    `CHK("nest", 8'h0A, c)
    end_of_service_code(c);
    cpu_if <= 1'b1;
    n = 0;
    repeat (12) begin
      @(posedge pclk);
      if (cpu_req.valid !== 1'b0) n++;
    end
    `CHK("blocked", 0, n)
    cpu_if <= 1'b0;
    end_of_service_code(8'h0E);
    svc(1'b1, c);
    `CHK("unblocked", 8'h0E, c)
    end_of_service_code(c);
    wr(OFS_CTRL, 32'h2);
    fire(12'h020);
    svc(1'b1, c);
    fire(12'h020);
    svc(1'b1, c);
    `CHK("special", 8'h0C, c)
    end_of_service_code(c);
    // Slave mode: programmed base, master type on pin 0, pin 1 held off
    cas <= 8'h20 + 8'($urandom_range(31));
    wr(OFS_SBASE, 32'h20);
    wr(OFS_CTRL, 32'h1);
    fire(12'h069);
    q = {8'h20, 8'h22, cas};
    while (q.size() > 0) begin
      x = q.pop_front();
      svc(1'b1, c);
      `CHK("slave", x, c)
      wr(OFS_EOI, 32'h8000);
    end
    wr(OFS_CTRL, 32'h0);
    svc(1'b1, c);
    `CHK("slave off", 8'h0D, c)
    end_of_service_code(c);
    summarize();
  end
endmodule
